// >>> common/adcc_pkg.sv
`default_nettype none

package adcc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RESULT   = 8'h25;
  localparam logic [7:0] ADDR_CTRL     = 8'h26;
  localparam logic [7:0] ADDR_CLKSET   = 8'h27;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h2D;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h2E;

  // ------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] RESULT_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [1:0] CKSEL_RST    = 2'h0;
  localparam logic [1:0] IRQ_RST      = 2'h0;
  localparam int         IRQ_W        = 2;
  localparam int         IRQ_DONE     = 0;
  localparam int         IRQ_RESTART  = 1;
  localparam int         CLKSET_TEST  = 7;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int         CLK_PERIOD_NS = 5;
  localparam logic [1:0] CKSEL_DIV2    = 2'h0;
  localparam logic [1:0] CKSEL_DIV8    = 2'h1;
  localparam logic [1:0] CKSEL_DIV32   = 2'h2;
  localparam logic [5:0] DIV_BY2       = 6'h02;
  localparam logic [5:0] DIV_BY8       = 6'h08;
  localparam logic [5:0] DIV_BY32      = 6'h20;
  localparam logic [6:0] SAMPLE_TAD    = 7'h20;
  localparam logic [6:0] TOTAL_TAD     = 7'h4C;
  localparam logic [2:0] DECIDE_PH     = 3'h4;
  localparam logic [3:0] RES_BITS      = 4'h8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       start;
    logic       pending;
    logic       rsv5;
    logic [1:0] cfg;
    logic       rsv2;
    logic [1:0] chan;
  } adcc_ctrl_s;

  typedef struct packed {
    logic       power;
    logic       sample;
    logic [1:0] chan;
    logic [3:0] analog_en;
    logic [7:0] dac;
  } adcc_ana_s;

  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_ARMED = 2'b01,
    ADCC_CONV  = 2'b10
  } adcc_state_e;

endpackage

`default_nettype wire

// >>> design/adcc_end.sv
`timescale 1ns/1ps

// >>> design/adcc_sar.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_sar (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_tick,
  input  wire logic       i_arm,
  input  wire logic       i_go,
  input  wire logic       i_stop,
  input  wire logic       i_cmp,
  output logic [7:0]      o_code,
  output logic            o_sample,
  output logic            o_busy,
  output logic            o_done
);

  adcc_pkg::adcc_state_e state;
  logic [6:0]            tad_cnt;
  logic [2:0]            ph;
  logic [3:0]            bit_cnt;

  wire       in_sar  = tad_cnt >= adcc_pkg::SAMPLE_TAD;
  wire       last    = tad_cnt == (adcc_pkg::TOTAL_TAD - 7'h01);
  wire       trial   = in_sar && (bit_cnt < adcc_pkg::RES_BITS);
  wire [2:0] pos     = 3'h7 - bit_cnt[2:0];
  wire       step    = (state == adcc_pkg::ADCC_CONV) && i_tick;
  wire       finish  = step && last && !i_arm && !i_stop;

  assign o_busy   = state == adcc_pkg::ADCC_CONV;
  assign o_sample = o_busy && !in_sar;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state <= adcc_pkg::ADCC_IDLE;
    end else if (i_arm) begin
      state <= adcc_pkg::ADCC_ARMED;
    end else if (i_stop) begin
      state <= adcc_pkg::ADCC_IDLE;
    end else begin
      case (state)
        adcc_pkg::ADCC_ARMED: begin
          if (i_go) begin
            state <= adcc_pkg::ADCC_CONV;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          if (step && last) begin
            state <= adcc_pkg::ADCC_IDLE;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Period counter and approximation register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || i_arm) begin
      tad_cnt <= 7'h00;
      ph      <= 3'h0;
      bit_cnt <= 4'h0;
      o_code  <= 8'h00;
    end else if (step) begin
      tad_cnt <= tad_cnt + 7'h01;
      if (trial) begin
        if (ph == 3'h0) begin
          o_code[pos] <= 1'b1;
        end
        if (ph == adcc_pkg::DECIDE_PH) begin
          o_code[pos] <= i_cmp;
          ph          <= 3'h0;
          bit_cnt     <= bit_cnt + 4'h1;
        end else begin
          ph <= ph + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else begin
      o_done <= finish;
    end
  end

endmodule

`default_nettype wire

// >>> design/adcc_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module adcc_top (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_b,
  input  wire logic [7:0]          i_addr,
  input  wire logic [7:0]          i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic [7:0]               o_rdata,
  input  wire logic                i_cmp,
  output var adcc_pkg::adcc_ana_s  o_ana,
  output logic                     o_irq
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [5:0] div_of(input logic [1:0] sel);
    case (sel)
      adcc_pkg::CKSEL_DIV2: div_of = adcc_pkg::DIV_BY2;
      adcc_pkg::CKSEL_DIV8: div_of = adcc_pkg::DIV_BY8;
      default:              div_of = adcc_pkg::DIV_BY32;
    endcase
  endfunction

  function automatic logic [3:0] lines_of(input logic [1:0] cfg);
    case (cfg)
      2'h1:    lines_of = 4'h1;
      2'h2:    lines_of = 4'h3;
      2'h3:    lines_of = 4'hF;
      default: lines_of = 4'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  adcc_pkg::adcc_ctrl_s   ctrl;
  logic [1:0]             cksel;
  logic                   cktest;
  logic [7:0]             result;
  logic [1:0]             irq_stat;
  logic [1:0]             irq_en;
  logic                   start_prev;
  logic [5:0]             div_cnt;
  logic                   tick;
  logic                   cmp_s1;
  logic                   cmp_s2;
  logic [7:0]             sar_code;
  logic                   sar_sample;
  logic                   busy;
  logic                   conv_done;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire       wr_ctrl    = i_wr && (i_addr == adcc_pkg::ADDR_CTRL);
  wire       wr_clkset  = i_wr && (i_addr == adcc_pkg::ADDR_CLKSET);
  wire       wr_irq_en  = i_wr && (i_addr == adcc_pkg::ADDR_IRQ_EN);
  wire       wr_irq_clr = i_wr && (i_addr == adcc_pkg::ADDR_IRQ_CLR);
  wire       wr_result  = i_wr && (i_addr == adcc_pkg::ADDR_RESULT);

  wire       start_rise = ctrl.start && !start_prev;
  wire       start_fall = !ctrl.start && start_prev;
  wire       pwr_on     = ctrl.cfg != 2'h0;
  wire       restart    = start_rise && ctrl.pending;
  wire [5:0] div_lim    = div_of(cksel) - 6'h01;

  wire [7:0] ctrl_rd    = {ctrl.start, ctrl.pending, 1'b0, ctrl.cfg, 1'b0, ctrl.chan};
  wire [7:0] clk_rd     = {cktest, 5'h00, cksel};
  wire [7:0] stat_rd    = {6'h00, irq_stat};
  wire [7:0] en_rd      = {6'h00, irq_en};

  wire [7:0] rd_val     = (i_addr == adcc_pkg::ADDR_RESULT)   ? result  :
                          (i_addr == adcc_pkg::ADDR_CTRL)     ? ctrl_rd :
                          (i_addr == adcc_pkg::ADDR_CLKSET)   ? clk_rd  :
                          (i_addr == adcc_pkg::ADDR_IRQ_STAT) ? stat_rd :
                          (i_addr == adcc_pkg::ADDR_IRQ_EN)   ? en_rd   :
                          8'h00;

  wire       next_pend  = start_rise ? 1'b1 :
                          (conv_done || !pwr_on) ? 1'b0 : ctrl.pending;

  wire [1:0] events     = {restart, conv_done};
  wire [1:0] clr_bits   = wr_irq_clr ? i_wdata[1:0] : 2'h0;
  wire [1:0] next_stat  = (irq_stat & ~clr_bits) | events;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ctrl <= adcc_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl.start <= i_wdata[7];
        ctrl.cfg   <= i_wdata[4:3];
        ctrl.chan  <= i_wdata[1:0];
      end
      ctrl.pending <= next_pend;
      ctrl.rsv5    <= 1'b0;
      ctrl.rsv2    <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cksel  <= adcc_pkg::CKSEL_RST;
      cktest <= 1'b0;
    end else if (wr_clkset) begin
      cksel  <= i_wdata[1:0];
      cktest <= i_wdata[adcc_pkg::CLKSET_TEST];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= ctrl.start;
    end
  end

  // ------------------------------------------------------------
  // Converter clock divider
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || div_cnt >= div_lim) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= div_cnt >= div_lim;
    end
  end

  // ------------------------------------------------------------
  // Comparator synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      cmp_s1 <= i_cmp;
      cmp_s2 <= cmp_s1;
    end
  end

  // ------------------------------------------------------------
  // Conversion engine
  // ------------------------------------------------------------
  adcc_sar u_sar (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_tick    (tick),
    .i_arm     (start_rise),
    .i_go      (start_fall),
    .i_stop    (!pwr_on),
    .i_cmp     (cmp_s2),
    .o_code    (sar_code),
    .o_sample  (sar_sample),
    .o_busy    (busy),
    .o_done    (conv_done)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      result <= adcc_pkg::RESULT_RST;
    end else if (conv_done) begin
      result <= sar_code;
    end
  end

  // ------------------------------------------------------------
  // Analog side
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_ana <= '0;
    end else begin
      o_ana.power     <= pwr_on;
      o_ana.analog_en <= lines_of(ctrl.cfg);
      o_ana.chan      <= ctrl.chan;
      o_ana.sample    <= sar_sample;
      o_ana.dac       <= sar_code;
    end
  end

  // ------------------------------------------------------------
  // Interrupts and read port
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      irq_stat <= adcc_pkg::IRQ_RST;
      irq_en   <= adcc_pkg::IRQ_RST;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      if (wr_irq_en) begin
        irq_en <= i_wdata[1:0];
      end
      o_irq <= |(next_stat & irq_en);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_val : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [6:0] tad_seen;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || start_fall) begin
      tad_seen <= 7'h00;
    end else if (busy && tick) begin
      tad_seen <= tad_seen + 7'h01;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  result_ro_a: assert property (
    wr_result && !conv_done |=> $stable(result))
    else $error("result changed by a write");

  go_conv_a: assert property (
    start_fall && !start_rise && (ctrl.pending) && pwr_on && !conv_done
    && !busy |=> busy)
    else $error("conversion did not begin on start fall");

  arm_pend_a: assert property (
    start_rise |=> ctrl.pending && !busy)
    else $error("start rise did not arm converter");

  pend_clr_a: assert property (
    conv_done && !start_rise |=> !ctrl.pending)
    else $error("pending not cleared at completion");

  irq_set_a: assert property (
    conv_done |=> irq_stat[adcc_pkg::IRQ_DONE])
    else $error("completion flag not set");

  chan_route_a: assert property (
    ##1 o_ana.chan == $past(ctrl.chan))
    else $error("channel routing wrong");

  cfg_map_a: assert property (
    ##1 o_ana.analog_en == lines_of($past(ctrl.cfg)))
    else $error("analog line map wrong");

  pwr_off_a: assert property (
    ctrl.cfg == 2'h0 |=> !o_ana.power ##1 !busy)
    else $error("converter not powered off");

  div_step_a: assert property (
    disable iff (!i_rst_b || wr_clkset)
    tick && cksel == adcc_pkg::CKSEL_DIV8 && $stable(cksel)
    |=> !tick [*7] ##1 tick)
    else $error("divide by eight spacing wrong");

  rsv_zero_a: assert property (
    i_rd && i_addr == adcc_pkg::ADDR_CLKSET |=> o_rdata[6:2] == 5'h00)
    else $error("unused clock bits not zero");

  conv_len_a: assert property (
    conv_done |-> $past(tad_seen) == (adcc_pkg::TOTAL_TAD - 7'h01))
    else $error("conversion length not 76 periods");

  res_hold_a: assert property (
    busy && !conv_done |=> $stable(result))
    else $error("result moved during conversion");

  edge_seen_a: assert property (
    $rose(ctrl.start) |-> start_rise ##1 !start_rise)
    else $error("start edge not seen once");

  done_c: cover property (busy ##[1:1000] conv_done);
  restart_c: cover property (busy ##1 restart);
  irq_c: cover property ($rose(o_irq));

endmodule

`default_nettype wire

// >>> dv/adcc_ana_model.sv
`timescale 1ns/1ps
`default_nettype none

module adcc_ana_model (
  input  wire logic                i_ref_clk,
  input  wire adcc_pkg::adcc_ana_s i_ana,
  input  wire logic [3:0][7:0]     i_vin,
  output logic                     o_cmp
);
  // ------------------------------
  // Comparator on the routed line
  // ------------------------------
  logic       toggle = 1'b0;
  logic [7:0] level;
  logic       live;

  assign level = i_vin[i_ana.chan];
  assign live  = i_ana.power & i_ana.analog_en[i_ana.chan];
  assign o_cmp = live ? (level >= i_ana.dac) : toggle;

  // Unpowered or digital line gives no stable answer
  always @(posedge i_ref_clk) begin
    toggle <= ~toggle;
  end
endmodule

`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                clk = 1'b0;
  logic                rst_b;
  logic [7:0]          addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic                wr;
  logic                rd;
  logic                cmp;
  logic                irq;
  adcc_pkg::adcc_ana_s ana;
  logic [3:0][7:0]     vin;
  logic [7:0]          exp_q[$];
  string               name_q[$];
  logic                rd_d = 1'b0;
  logic [7:0]          last_res;
  int                  err_total;
  int                  cmp_count;

  always #(adcc_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;

  adcc_top dut (
    .i_ref_clk (clk),
    .i_rst_b   (rst_b),
    .i_addr    (addr),
    .i_wdata   (wdata),
    .i_wr      (wr),
    .i_rd      (rd),
    .o_rdata   (rdata),
    .i_cmp     (cmp),
    .o_ana     (ana),
    .o_irq     (irq)
  );

  adcc_ana_model u_model (
    .i_ref_clk (clk),
    .i_ana     (ana),
    .i_vin     (vin),
    .o_cmp     (cmp)
  );

  // ------------------------------
  // Checking and bus tasks
  // ------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    rd    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    addr <= a;
    wr   <= 1'b0;
    rd   <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(what);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
    end
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      check(name_q.pop_front(), {8'h00, exp_q.pop_front()}, {8'h00, rdata});
    end
    rd_d <= rd;
  end

  // ------------------------------
  // One full conversion
  // ------------------------------
  task automatic convert(input logic [1:0] ch, input logic [1:0] sel);
    int         div;
    int         n;
    int         s;
    logic [7:0] v;
    div = (sel == adcc_pkg::CKSEL_DIV2) ? 2 : (sel == adcc_pkg::CKSEL_DIV8) ? 8 : 32;
    v = 8'($urandom());
    vin[ch] <= v;
    n = 0;
    s = 0;
    wr_reg(adcc_pkg::ADDR_CLKSET, {6'h00, sel});
    wr_reg(adcc_pkg::ADDR_CTRL, {6'b100110, ch});
    idle(3);
    rd_reg(adcc_pkg::ADDR_CTRL, {6'b110110, ch}, "ctrl pending");
    idle(200);
    check("irq while start high", 16'h0, {15'h0, irq});
    check("channel", {14'h0, ch}, {14'h0, ana.chan});
    check("analog lines", 16'h000F, {12'h0, ana.analog_en});
    wr_reg(adcc_pkg::ADDR_CTRL, {6'b000110, ch});
    rd_reg(adcc_pkg::ADDR_RESULT, last_res, "result held");
    while (irq !== 1'b1 && n < 4000) begin
      idle(1);
      n++;
      s += int'(ana.sample);
    end
    n += 1;
    check("conversion span", 16'h1, {15'h0, n >= 75 * div + 3 && n <= 76 * div + 4});
    check("sample span", 16'h1, {15'h0, s >= 31 * div && s <= 32 * div + 1});
    rd_reg(adcc_pkg::ADDR_RESULT, v, "result");
    rd_reg(adcc_pkg::ADDR_CTRL, {6'b000110, ch}, "ctrl done");
    rd_reg(adcc_pkg::ADDR_IRQ_STAT, 8'h01, "irq status");
    if (ch == 2'h0) begin
      wr_reg(adcc_pkg::ADDR_IRQ_EN, 8'h00);
      idle(2);
      check("irq masked", 16'h0, {15'h0, irq});
      wr_reg(adcc_pkg::ADDR_IRQ_EN, 8'h01);
      idle(2);
      check("irq unmasked", 16'h1, {15'h0, irq});
    end
    wr_reg(adcc_pkg::ADDR_IRQ_CLR, 8'h01);
    idle(2);
    check("irq cleared", 16'h0, {15'h0, irq});
    last_res = v;
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    logic [7:0] regs [7];
    logic [3:0] lines [4];
    regs = '{adcc_pkg::ADDR_RESULT, adcc_pkg::ADDR_CTRL, adcc_pkg::ADDR_CLKSET,
             adcc_pkg::ADDR_IRQ_STAT, adcc_pkg::ADDR_IRQ_EN, adcc_pkg::ADDR_IRQ_CLR, 8'h30};
    lines = '{4'h0, 4'h1, 4'h3, 4'hF};
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    vin = '0;
    last_res = adcc_pkg::RESULT_RST;
    void'($urandom(32'h2AE3));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (regs[i]) rd_reg(regs[i], 8'h00, "reset value");
    idle(2);
    check("analog after reset", 16'h0, ana);
    wr_reg(8'h30, 8'hFF);
    wr_reg(adcc_pkg::ADDR_RESULT, 8'hA5);
    rd_reg(adcc_pkg::ADDR_RESULT, 8'h00, "result write");
    wr_reg(adcc_pkg::ADDR_CTRL, 8'h24);
    wr_reg(adcc_pkg::ADDR_CLKSET, 8'h7C);
    rd_reg(adcc_pkg::ADDR_CTRL, 8'h00, "ctrl unused bits");
    rd_reg(adcc_pkg::ADDR_CLKSET, 8'h00, "clock unused bits");
    for (int c = 0; c < 4; c++) begin
      wr_reg(adcc_pkg::ADDR_CTRL, 8'(c << 3));
      idle(3);
      check("analog lines", {12'h0, lines[c]}, {12'h0, ana.analog_en});
      check("power", {15'h0, c != 0}, {15'h0, ana.power});
    end
    wr_reg(adcc_pkg::ADDR_IRQ_EN, 8'h01);
    for (int i = 0; i < 4; i++) convert(2'(i), 2'(i % 3));
    wr_reg(adcc_pkg::ADDR_CTRL, 8'h9B);
    idle(3);
    wr_reg(adcc_pkg::ADDR_CTRL, 8'h1B);
    idle(20);
    wr_reg(adcc_pkg::ADDR_CTRL, 8'h9B);
    idle(3);
    rd_reg(adcc_pkg::ADDR_IRQ_STAT, 8'h02, "restart flag");
    wr_reg(adcc_pkg::ADDR_CTRL, 8'h00);
    idle(3);
    rd_reg(adcc_pkg::ADDR_CTRL, 8'h00, "ctrl after power off");
    idle(200);
    check("irq after abort", 16'h0, {15'h0, irq});
    check("power off", 16'h0, {15'h0, ana.power});
    rd_reg(adcc_pkg::ADDR_RESULT, last_res, "result kept");
    idle(3);
    end_of_test();
  end

  // ------------------------------
  // Watchdog
  // ------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule

`default_nettype wire
